// [verilog/acs_pkg.sv]
// Package for the audio clock source selection block: register map, fields and source codes.
package acs_pkg;
	// Register offsets on the control port.
	localparam logic [7:0] ACS_OFS_PLL_PRI = 8'h32;
	localparam logic [7:0] ACS_OFS_SEC = 8'h33;
	localparam logic [7:0] ACS_OFS_NM = 8'h34;
	// Reset values.
	localparam logic [7:0] ACS_RST_PLL_PRI = 8'h00;
	localparam logic [7:0] ACS_RST_SEC = 8'h00;
	localparam logic [7:0] ACS_RST_NM = 8'h10;
	// Field positions (low bit of each field).
	localparam int ACS_POS_PRESCALER = 6;
	localparam int ACS_POS_PRIMARY = 3;
	localparam int ACS_POS_SECONDARY = 4;
	localparam int ACS_POS_DIGITAL_NM = 6;
	localparam int ACS_POS_ANALOG_NM = 4;
	// Writable bit masks; reserved read-only bits read as their reset value.
	localparam logic [7:0] ACS_WMASK_PLL_PRI = 8'hf8;
	localparam logic [7:0] ACS_WMASK_SEC = 8'h70;
	localparam logic [7:0] ACS_WMASK_NM = 8'hff;
	// Index of each candidate source inside the sampled source vector.
	localparam logic [2:0] ACS_SRC_PLL = 3'h0;
	localparam logic [2:0] ACS_SRC_PRIMARY = 3'h1;
	localparam logic [2:0] ACS_SRC_SECONDARY = 3'h2;
	localparam logic [2:0] ACS_SRC_CONTROL = 3'h3;
	localparam logic [2:0] ACS_SRC_OSC = 3'h4;
	localparam logic [2:0] ACS_SRC_DSP = 3'h5;
	localparam logic [2:0] ACS_SRC_LOW_JITTER = 3'h6;
	localparam logic [2:0] ACS_SRC_NONE = 3'h7;
	// Number of clock destinations.
	localparam int ACS_NUM_DEST = 5;
	// Switch states of the glitch-free selector.
	typedef enum logic [1:0] {
		ACS_RUN = 2'b01,
		ACS_PARK = 2'b10
	} acs_state_e;
endpackage

// [verilog/acs_glitchless_mux.sv]
// Glitch-free selector that moves one destination clock from one sampled source to another.
`timescale 1ns/1ps
`default_nettype none
module acs_glitchless_mux
	import acs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] src_i,
	input wire logic [2:0] sel_i,
	output logic clk_o,
	output logic busy_o
);
	acs_state_e state;
	logic [2:0] cur;

	// The old source is followed until it is low, then the output parks low until the
	// new source is low too, so no high or low phase is ever cut short.
	// Leaving waits on the old source alone, not on the output as well: a source that
	// toggles every cycle is never low together with its delayed copy and would never be left.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= ACS_PARK;
			cur <= ACS_SRC_NONE;
			clk_o <= 1'b0;
		end else if (ce_i) begin
			unique case (state)
				ACS_RUN: begin
					clk_o <= src_i[cur]; // RULE_07
					if (sel_i != cur && !src_i[cur]) begin // RULE_07
						state <= ACS_PARK;
						clk_o <= 1'b0;
					end
				end
				ACS_PARK: begin
					clk_o <= 1'b0; // RULE_07
					if (!src_i[sel_i]) begin
						cur <= sel_i;
						state <= ACS_RUN;
					end
				end
			endcase
		end
	end

	// Busy while a requested source has not yet been taken over.
	assign busy_o = (state == ACS_PARK) || (sel_i != cur);

	property p_park_low;
		@(posedge core_clk_i) disable iff (rst_i)
		$past(state) == ACS_PARK |-> !clk_o;
	endproperty
	a_park_low: assert property (p_park_low) else $error("Output high while parked."); // RULE_07

	property p_switch_clean;
		@(posedge core_clk_i) disable iff (rst_i)
		(cur != $past(cur)) |-> !clk_o && $past(state) == ACS_PARK && !$past(src_i[sel_i]);
	endproperty
	a_switch_clean: assert property (p_switch_clean) // RULE_07
		else $error("Switch on a high level.");

	c_switch: cover property (@(posedge core_clk_i) disable iff (rst_i) cur != $past(cur));
endmodule
`default_nettype wire

// [verilog/acs_clock_select.sv]
// Top of the audio clock source selection block: control registers and five clock selectors.
// Contract
// RULE_01 - Bits 7-6 at 0x32 pick prescaler input: primary, secondary, control, oscillator.
// RULE_02 - Bits 5-3 at 0x32 pick primary divider source; codes 1, 6, 7 reserved.
// RULE_03 - Bits 6-4 at 0x33 pick secondary divider source; codes 2, 6, 7 reserved.
// RULE_04 - Bits 7-6 at 0x34 pick digital N/M input: primary, secondary, control, oscillator.
// RULE_05 - Bits 5-4 at 0x34 pick analog N/M input; reset code is 1.
// RULE_06 - Host writes only reset values into reserved fields.
// RULE_07 - Source changes switch the destination clock without glitches or runt pulses.
`timescale 1ns/1ps
`default_nettype none
module acs_clock_select
	import acs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic pll_clk_i,
	input wire logic primary_bitclk_i,
	input wire logic secondary_bitclk_i,
	input wire logic control_port_clock_i,
	input wire logic osc_clk_i,
	input wire logic dsp_clk_i,
	output logic prescaler_input_clock_o,
	output logic primary_divider_clock_o,
	output logic secondary_divider_clock_o,
	output logic digital_nm_clock_o,
	output logic analog_nm_clock_o,
	output logic [4:0] switch_busy_o
);
	logic [7:0] reg_pll_pri;
	logic [7:0] reg_sec;
	logic [7:0] reg_nm;
	logic [7:0] src_vec;
	logic [2:0] req [ACS_NUM_DEST];
	logic [ACS_NUM_DEST-1:0] dest_clk;

	// Four-way choice shared by the prescaler and the digital N/M path.
	function automatic logic [2:0] map_four(input logic [1:0] code);
		unique case (code)
			2'h0: map_four = ACS_SRC_PRIMARY;
			2'h1: map_four = ACS_SRC_SECONDARY;
			2'h2: map_four = ACS_SRC_CONTROL;
			default: map_four = ACS_SRC_OSC;
		endcase
	endfunction

	// Divider source choice; the code that would point a port at itself is reserved.
	function automatic logic [2:0] map_divider(input logic [2:0] code, input logic [2:0] alt);
		unique case (code)
			3'h0: map_divider = ACS_SRC_PLL;
			3'h3: map_divider = ACS_SRC_CONTROL;
			3'h4: map_divider = ACS_SRC_OSC;
			3'h5: map_divider = ACS_SRC_DSP;
			default: map_divider = alt;
		endcase
	endfunction

	// Register writes; read-only reserved bits keep their reset value whatever is written.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_pll_pri <= ACS_RST_PLL_PRI;
			reg_sec <= ACS_RST_SEC;
			reg_nm <= ACS_RST_NM; // RULE_05
		end else if (ce_i && wr_en_i) begin
			unique case (addr_i)
				ACS_OFS_PLL_PRI: reg_pll_pri <= (wdata_i & ACS_WMASK_PLL_PRI) |
					(ACS_RST_PLL_PRI & ~ACS_WMASK_PLL_PRI); // RULE_06
				ACS_OFS_SEC: reg_sec <= (wdata_i & ACS_WMASK_SEC) |
					(ACS_RST_SEC & ~ACS_WMASK_SEC); // RULE_06
				ACS_OFS_NM: reg_nm <= wdata_i;
				default: ;
			endcase
		end
	end

	// Read data is registered; unmapped offsets read as zero.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i && rd_en_i) begin
			unique case (addr_i)
				ACS_OFS_PLL_PRI: rdata_o <= reg_pll_pri;
				ACS_OFS_SEC: rdata_o <= reg_sec;
				ACS_OFS_NM: rdata_o <= reg_nm;
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	// Candidate sources, sampled as synchronous levels; the low-jitter path is the primary clock.
	assign src_vec = {1'b0, primary_bitclk_i, dsp_clk_i, osc_clk_i, control_port_clock_i,
		secondary_bitclk_i, primary_bitclk_i, pll_clk_i};

	// Requested source per destination; reserved codes park the destination low.
	always_comb begin
		req[0] = map_four(reg_pll_pri[ACS_POS_PRESCALER +: 2]); // RULE_01
		req[1] = (reg_pll_pri[ACS_POS_PRIMARY +: 3] == 3'h2) ? ACS_SRC_SECONDARY :
			map_divider(reg_pll_pri[ACS_POS_PRIMARY +: 3], ACS_SRC_NONE); // RULE_02
		req[2] = (reg_sec[ACS_POS_SECONDARY +: 3] == 3'h1) ? ACS_SRC_PRIMARY :
			map_divider(reg_sec[ACS_POS_SECONDARY +: 3], ACS_SRC_NONE); // RULE_03
		req[3] = map_four(reg_nm[ACS_POS_DIGITAL_NM +: 2]); // RULE_04
		unique case (reg_nm[ACS_POS_ANALOG_NM +: 2]) // RULE_05
			2'h0, 2'h1: req[4] = ACS_SRC_PLL;
			2'h2: req[4] = map_four(reg_nm[ACS_POS_DIGITAL_NM +: 2]);
			default: req[4] = ACS_SRC_LOW_JITTER;
		endcase
	end

	// One glitch-free selector per destination.
	for (genvar d = 0; d < ACS_NUM_DEST; d++) begin : g_dest
		acs_glitchless_mux u_mux (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.src_i(src_vec),
			.sel_i(req[d]),
			.clk_o(dest_clk[d]),
			.busy_o(switch_busy_o[d])
		);
	end

	assign prescaler_input_clock_o = dest_clk[0];
	assign primary_divider_clock_o = dest_clk[1];
	assign secondary_divider_clock_o = dest_clk[2];
	assign digital_nm_clock_o = dest_clk[3];
	assign analog_nm_clock_o = dest_clk[4];

	property p_prescaler_code;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_pll_pri[7:6] == 2'h2 |-> req[0] == ACS_SRC_CONTROL;
	endproperty
	a_prescaler_code: assert property (p_prescaler_code) // RULE_01
		else $error("Prescaler map wrong.");

	property p_prescaler_reset;
		@(posedge core_clk_i)
		rst_i |=> req[0] == ACS_SRC_PRIMARY;
	endproperty
	a_prescaler_reset: assert property (p_prescaler_reset) // RULE_01
		else $error("Prescaler reset code wrong.");

	property p_primary_reserved;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_pll_pri[5:3] inside {3'h1, 3'h6, 3'h7} |-> req[1] == ACS_SRC_NONE;
	endproperty
	a_primary_reserved: assert property (p_primary_reserved) // RULE_02
		else $error("Reserved code used.");

	property p_primary_choice;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_pll_pri[5:3] == 3'h2 |-> req[1] == ACS_SRC_SECONDARY;
	endproperty
	a_primary_choice: assert property (p_primary_choice) // RULE_02
		else $error("Primary map wrong.");

	property p_primary_dsp;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_pll_pri[5:3] == 3'h5 |-> req[1] == ACS_SRC_DSP;
	endproperty
	a_primary_dsp: assert property (p_primary_dsp) // RULE_02
		else $error("Primary DSP map wrong.");

	property p_primary_read_only;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && wr_en_i && addr_i == ACS_OFS_PLL_PRI |=> reg_pll_pri[2:0] == 3'h0;
	endproperty
	a_primary_read_only: assert property (p_primary_read_only) // RULE_06
		else $error("Read-only bits written.");

	property p_secondary_write;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && wr_en_i && addr_i == ACS_OFS_SEC && wdata_i[6:4] == 3'h1
			|=> req[2] == ACS_SRC_PRIMARY && reg_sec[3:0] == 4'h0 && !reg_sec[7];
	endproperty
	a_secondary_write: assert property (p_secondary_write) // RULE_03
		else $error("Secondary map wrong.");

	property p_secondary_reserved;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_sec[6:4] inside {3'h2, 3'h6, 3'h7} |-> req[2] == ACS_SRC_NONE;
	endproperty
	a_secondary_reserved: assert property (p_secondary_reserved) // RULE_03
		else $error("Secondary reserved code used.");

	property p_digital_code;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_nm[7:6] == 2'h1 |-> req[3] == ACS_SRC_SECONDARY;
	endproperty
	a_digital_code: assert property (p_digital_code) // RULE_04
		else $error("Digital N/M map wrong.");

	property p_digital_osc;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_nm[7:6] == 2'h3 |-> req[3] == ACS_SRC_OSC;
	endproperty
	a_digital_osc: assert property (p_digital_osc) // RULE_04
		else $error("Digital N/M oscillator map wrong.");

	property p_analog_reset;
		@(posedge core_clk_i)
		rst_i |=> reg_nm == 8'h10 && req[4] == ACS_SRC_PLL;
	endproperty
	a_analog_reset: assert property (p_analog_reset) // RULE_05
		else $error("Analog reset code wrong.");

	property p_analog_follow;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_nm[5:4] == 2'h2 |-> req[4] == req[3];
	endproperty
	a_analog_follow: assert property (p_analog_follow) // RULE_05
		else $error("Analog follow wrong.");

	property p_analog_low_jitter;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_nm[5:4] == 2'h3 |-> req[4] == ACS_SRC_LOW_JITTER;
	endproperty
	a_analog_low_jitter: assert property (p_analog_low_jitter) // RULE_05
		else $error("Analog low-jitter map wrong.");

	c_write_pri: cover property (@(posedge core_clk_i) ce_i && wr_en_i && addr_i == ACS_OFS_PLL_PRI);
	c_low_jitter: cover property (@(posedge core_clk_i) req[4] == ACS_SRC_LOW_JITTER);
	c_read_nm: cover property (@(posedge core_clk_i) ce_i && rd_en_i && addr_i == ACS_OFS_NM);
endmodule
`default_nettype wire

// [testbench/acs_src_model.sv]
// Candidate clock sources that sit on the far side of the selector.
`timescale 1ns/1ps
`default_nettype none
module acs_src_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	output logic [5:0] clks_o
);
	logic [15:0] cnt = 16'h0000;
	// Free-running count, moved just after the edge like any synchronous source.
	always @(posedge core_clk_i) begin
		cnt <= #1 rst_i ? 16'h0000 : cnt + 16'h0001;
	end
	// Half periods 1, 2, 3, 4, 5 and 7 cycles, so each source leaves its own trace.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			clks_o[i] = 1'((int'(cnt) / (i + 1 + i / 5)) % 2);
		end
	end
endmodule
`default_nettype wire

// [testbench/acs_clock_select_tb.sv]
// Self-checking bench for the audio clock source selection block.
`timescale 1ns/1ps
`default_nettype none
module acs_clock_select_tb;
	import acs_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	wire [7:0] rdata_o;
	wire [5:0] clks;
	wire [4:0] outs;
	wire [4:0] switch_busy_o;
	wire [7:0] srcs = {1'b0, clks[1], clks};
	logic [7:0] r[3];
	int num_errors = 0;
	int total_checks = 0;

	// Free-running core clock.
	always #10 core_clk_i = ~core_clk_i;

	acs_src_model src_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .clks_o(clks));
	acs_clock_select dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .pll_clk_i(clks[0]), .primary_bitclk_i(clks[1]),
		.secondary_bitclk_i(clks[2]), .control_port_clock_i(clks[3]), .osc_clk_i(clks[4]),
		.dsp_clk_i(clks[5]), .prescaler_input_clock_o(outs[0]),
		.primary_divider_clock_o(outs[1]), .secondary_divider_clock_o(outs[2]),
		.digital_nm_clock_o(outs[3]), .analog_nm_clock_o(outs[4]),
		.switch_busy_o(switch_busy_o));

	task automatic tick();
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		tick();
		wr_en_i = 1'b0;
		tick();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		rd_en_i = 1'b1;
		addr_i = a;
		tick();
		rd_en_i = 1'b0;
		cmp($sformatf("reg %h", a), exp, rdata_o);
		tick();
	endtask
	// Expected source index for a destination and its code.
	function automatic logic [2:0] src_of(int d, logic [2:0] c);
		logic [2:0] four[4] = '{ACS_SRC_PRIMARY, ACS_SRC_SECONDARY, ACS_SRC_CONTROL, ACS_SRC_OSC};
		logic [2:0] pri[8] = '{ACS_SRC_PLL, ACS_SRC_NONE, ACS_SRC_SECONDARY, ACS_SRC_CONTROL,
			ACS_SRC_OSC, ACS_SRC_DSP, ACS_SRC_NONE, ACS_SRC_NONE};
		case (d)
			1: return pri[c];
			2: return c == 1 ? ACS_SRC_PRIMARY : (c == 2 ? ACS_SRC_NONE : pri[c]);
			4: return c < 2 ? ACS_SRC_PLL : (c == 2 ? four[r[2][7:6]] : ACS_SRC_PRIMARY);
			default: return four[c[1:0]];
		endcase
	endfunction
	// Program one field, read it back, then follow the destination for 16 cycles.
	task automatic sel(int d, logic [2:0] c);
		int p[5] = '{ACS_POS_PRESCALER, ACS_POS_PRIMARY, ACS_POS_SECONDARY, ACS_POS_DIGITAL_NM,
			ACS_POS_ANALOG_NM};
		int k;
		logic [7:0] m;
		logic [2:0] s;
		logic was;
		k = d < 2 ? 0 : (d == 2 ? 1 : 2);
		m = (d == 1 || d == 2) ? 8'h07 : 8'h03;
		r[k] = (r[k] & ~(m << p[d])) | ((8'(c) & m) << p[d]);
		wr(8'h32 + 8'(k), r[k]);
		rd(8'h32 + 8'(k), r[k]);
		s = src_of(d, c);
		for (int i = 0; i < 64 && switch_busy_o[d] !== 1'b0; i++) tick();
		cmp("busy", 8'h00, {7'h00, switch_busy_o[d]});
		repeat (16) begin
			@(negedge core_clk_i);
			was = srcs[s];
			tick();
			cmp($sformatf("dest %0d code %0d", d, c), {7'h00, was}, {7'h00, outs[d]});
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence; host writes keep reserved bits at their reset value.
	initial begin
		repeat (16) tick();
		rst_i = 1'b0;
		r = '{8'h00, 8'h00, 8'h10};
		rd(8'h32, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h34, 8'h10);
		wr(8'h31, 8'hc0);
		rd(8'h31, 8'h00);
		ce_i = 1'b0;
		wr(8'h34, 8'hc0);
		ce_i = 1'b1;
		rd(8'h34, 8'h10);
		$display("test registers done");
		for (int c = 0; c < 4; c++) sel(0, 3'(c));
		for (int c = 0; c < 8; c++) sel(1, 3'(c));
		for (int c = 0; c < 8; c++) sel(2, 3'(c));
		for (int c = 0; c < 4; c++) sel(3, 3'(c));
		for (int c = 0; c < 4; c++) sel(4, 3'(c));
		sel(3, 3'h1);
		sel(4, 3'h2);
		$display("test selectors done");
		conclude();
	end

	// Watchdog well beyond the longest possible run of under 2600 cycles.
	initial begin
		#(20 * 20000);
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire
